// file: mhc_charge_timer.sv
// Charge-time measurement of the RC network against the reference comparator.
`timescale 1ns/1ps
`default_nettype none
module mhc_charge_timer
    import mhc_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic      mclk,      // System clock.
    input  wire logic      reset,     // Synchronous reset, active high.
    input  wire logic      start,     // Pulse: charge released, begin timing.
    input  wire logic      cmp_trip,  // Comparator: capacitor above reference.
    output logic           busy,      // Timing in progress.
    output logic           done,      // Pulse: result valid.
    output mhc_meas_s      result     // Charge time and overflow mark.
);
    if (CNT_W != 8) begin : g_bad_width
        $error("mhc_charge_timer: CNT_W must match the reading width of 8");
    end

    mhc_meas_e  state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [7:0] pre_reg, pre_next;
    logic       done_reg, done_next;
    mhc_meas_s  res_reg, res_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        pre_next   = pre_reg;
        done_next  = 1'b0;
        res_next   = res_reg;
        case (state_reg)
            MHC_MEAS_IDLE: begin
                if (start) begin
                    state_next = MHC_MEAS_BUSY;
                    cnt_next   = 8'h00;
                    pre_next   = 8'h00;
                end
            end
            default: begin
                if (cmp_trip) begin
                    state_next = MHC_MEAS_IDLE;
                    done_next  = 1'b1;
                    res_next   = '{count: cnt_reg, over: 1'b0};
                end else if (pre_reg == TICK_DIV - 8'h01) begin
                    pre_next = 8'h00;
                    if (cnt_reg == 8'hff) begin
                        state_next = MHC_MEAS_IDLE;
                        done_next  = 1'b1;
                        res_next   = '{count: 8'hff, over: 1'b1};
                    end else begin
                        cnt_next = cnt_reg + 8'h01;
                    end
                end else begin
                    pre_next = pre_reg + 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_reg <= MHC_MEAS_IDLE;
            cnt_reg   <= 8'h00;
            pre_reg   <= 8'h00;
            done_reg  <= 1'b0;
            res_reg   <= '{count: READING_RST, over: 1'b0};
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            pre_reg   <= pre_next;
            done_reg  <= done_next;
            res_reg   <= res_next;
        end
    end

    assign busy   = (state_reg == MHC_MEAS_BUSY);
    assign done   = done_reg;
    assign result = res_reg;
endmodule
`default_nettype wire

// file: mhc_heater_ctrl.sv
// Mains-synchronised heater controller: frames, measurements, regulator, gate, debug serial.
//
// How it works
// - Frames of 32 mains periods, 0.64 s.
// - Sync rising edge starts frame, leaves wait.
// - Gate edges follow sync, near zero crossing.
// - Measure in periods 28 and 30, positive start.
// - Count charge time until comparator trips.
// - Separate charge outputs select sensor or setpoint.
// - One gate pulse per positive half-wave of an on-period.
// - First periods on, remaining periods off.
// - PI regulator with clamped duty limits.
// - First frame measures only; flags setpoint change.
// - Full power until start_pct percent of setpoint.
// - Setpoint change forces max or zero duty.
// - Debug serial sends single-byte messages only.
// - Dial off position gives zero duty.
`timescale 1ns/1ps
`default_nettype none
module mhc_heater_ctrl
    import mhc_pkg::*;
#(
    parameter logic [5:0]  DUTY_MIN  = 6'h00,  // Lowest regulated duty in periods.
    parameter logic [5:0]  DUTY_MAX  = 6'h20,  // Highest duty in periods.
    parameter logic [3:0]  KP        = 4'h2,   // Proportional gain.
    parameter int unsigned KI_SHIFT  = 3,      // Integral weight as right shift.
    parameter logic [15:0] INTEG_LIM = 16'h03ff // Integrator clamp magnitude.
) (
    input  wire logic mclk,                   // System clock, 20 MHz.
    input  wire logic reset,                  // Synchronous reset, active high.
    input  wire logic mains_sync_wake_input,  // High during positive half-wave.
    input  wire logic reference_comparator,   // High once capacitor is above reference.
    input  wire logic [7:0] start_pct,        // Full-power exit threshold, percent.
    output logic      sensor_charge_output,   // Charges capacitor through sensor.
    output logic      setpoint_charge_output, // Charges capacitor through dial.
    output logic      gate_drive,             // Power switch gate.
    output logic      debug_serial_tx,        // Asynchronous debug line, idle high.
    output logic      frame_start,            // Pulse at each frame start.
    output logic      change_flag,            // Setpoint change pending.
    output logic      reading_fault           // Last reading out of range.
);
    if (DUTY_MAX > FRAME_PERIODS || DUTY_MIN > DUTY_MAX || KI_SHIFT > 8) begin : g_bad_par
        $error("mhc_heater_ctrl: duty limits or integral shift out of range");
    end

    // Sync edge detection; the input is already synchronous to mclk.
    logic sync_d_reg;
    logic sync_rise;
    assign sync_rise = mains_sync_wake_input & ~sync_d_reg;

    // Frame state.
    mhc_frame_e  fstate_reg, fstate_next;
    logic [5:0]  period_reg, period_next;
    logic [5:0]  duty_reg, duty_next;
    logic        first_reg, first_next;
    logic        startup_reg, startup_next;
    logic        chg_reg, chg_next;
    logic [7:0]  temp_reg, temp_next;
    logic [7:0]  set_reg, set_next;
    logic [7:0]  prev_set_reg, prev_set_next;
    logic [15:0] integ_reg, integ_next;
    logic        fault_reg, fault_next;
    logic        fstart_reg, fstart_next;
    logic        gate_reg, gate_next;
    logic        scharge_reg, scharge_next;
    logic        pcharge_reg, pcharge_next;

    // Measurement unit.
    logic      meas_start;
    logic      meas_busy;
    logic      meas_done;
    mhc_meas_s meas_res;

    mhc_charge_timer #(.CNT_W(8)) u_timer (
        .mclk     (mclk),
        .reset    (reset),
        .start    (meas_start),
        .cmp_trip (reference_comparator),
        .busy     (meas_busy),
        .done     (meas_done),
        .result   (meas_res)
    );

    // Regulator arithmetic, evaluated against the readings of the frame just ended.
    logic [16:0]        temp_x100, set_x_start, set_x_rise, set_x_fall;
    logic signed [15:0] err, p_term, i_sum, pi_out;
    logic [5:0]         pi_duty;

    always_comb begin
        temp_x100   = 17'({9'h000, temp_reg} * 17'd100);
        set_x_start = 17'({9'h000, set_reg} * {9'h000, start_pct});
        set_x_rise  = 17'({9'h000, set_reg} * {9'h000, RISE_PCT});
        set_x_fall  = 17'({9'h000, set_reg} * {9'h000, FALL_PCT});
        err         = $signed({8'h00, set_reg}) - $signed({8'h00, temp_reg});
        p_term      = 16'(err * $signed({12'h000, KP}));
        i_sum       = $signed(integ_reg) + err;
        if (i_sum > $signed(INTEG_LIM)) begin
            i_sum = $signed(INTEG_LIM);
        end else if (i_sum < -$signed(INTEG_LIM)) begin
            i_sum = -$signed(INTEG_LIM);
        end
        pi_out = p_term + (i_sum >>> KI_SHIFT);
        if (pi_out < $signed({10'h000, DUTY_MIN})) begin
            pi_duty = DUTY_MIN;
        end else if (pi_out > $signed({10'h000, DUTY_MAX})) begin
            pi_duty = DUTY_MAX;
        end else begin
            pi_duty = pi_out[5:0];
        end
    end

    // Frame sequencing, measurement scheduling and duty decision.
    always_comb begin
        fstate_next   = fstate_reg;
        period_next   = period_reg;
        duty_next     = duty_reg;
        first_next    = first_reg;
        startup_next  = startup_reg;
        chg_next      = chg_reg;
        temp_next     = temp_reg;
        set_next      = set_reg;
        prev_set_next = prev_set_reg;
        integ_next    = integ_reg;
        fault_next    = fault_reg;
        fstart_next   = 1'b0;
        scharge_next  = scharge_reg;
        pcharge_next  = pcharge_reg;
        meas_start    = 1'b0;

        if (sync_rise) begin
            if (fstate_reg == MHC_WAIT || period_reg == FRAME_PERIODS) begin
                fstate_next = MHC_RUN;
                period_next = 6'h01;
                fstart_next = 1'b1;
                // The frame out of the wait state only measures; the next one is regulated.
                if (fstate_reg == MHC_WAIT) begin
                    duty_next = DUTY_RST;
                end else begin
                    first_next    = 1'b0;
                    prev_set_next = set_reg;
                    if (set_reg != prev_set_reg) begin
                        chg_next = 1'b1;
                    end
                    if (set_reg <= SETPOINT_OFF || fault_reg) begin
                        duty_next  = 6'h00;
                        integ_next = INTEG_RST;
                    end else if (startup_reg && temp_x100 < set_x_start) begin
                        duty_next = DUTY_MAX;
                    end else if ((chg_reg || set_reg != prev_set_reg)
                                 && temp_x100 < set_x_rise) begin
                        duty_next    = DUTY_MAX;
                        startup_next = 1'b0;
                    end else if ((chg_reg || set_reg != prev_set_reg)
                                 && temp_x100 > {1'b0, set_x_fall[15:0]} + set_x_fall / 17'd8) begin
                        duty_next    = 6'h00;
                        startup_next = 1'b0;
                        integ_next   = INTEG_RST;
                    end else begin
                        startup_next = 1'b0;
                        chg_next     = 1'b0;
                        duty_next    = pi_duty;
                        integ_next   = 16'(i_sum);
                    end
                end
            end else if (fstate_reg == MHC_RUN) begin
                period_next = period_reg + 6'h01;
            end
            // Both readings sit at the tail of the frame so the heater current has
            // already been decided; it flows during sensor timing at a duty of 28 or more, during dial timing at 30 or more.
            if (fstate_reg == MHC_RUN && !meas_busy) begin
                if (period_next == MEAS_SENSOR_PER) begin
                    meas_start   = 1'b1;
                    scharge_next = 1'b1;
                end else if (period_next == MEAS_SETPOINT_PER) begin
                    meas_start   = 1'b1;
                    pcharge_next = 1'b1;
                end
            end
        end

        if (meas_done) begin
            scharge_next = 1'b0;
            pcharge_next = 1'b0;
            fault_next   = meas_res.over;
            if (scharge_reg) begin
                temp_next = meas_res.count;
            end else begin
                set_next = meas_res.over ? 8'h00 : meas_res.count;
                if (first_reg && set_next != prev_set_reg) begin
                    chg_next = 1'b1;
                end
            end
        end
    end

    // Gate is high only inside the positive half-wave of an on-period, so it rises
    // and falls with the sync edges and ends where the negative half-wave begins.
    always_comb begin
        gate_next = (fstate_next == MHC_RUN) && mains_sync_wake_input
                    && (period_next != 6'h00) && (period_next <= duty_next);
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sync_d_reg   <= 1'b0;
            fstate_reg   <= MHC_WAIT;
            period_reg   <= 6'h00;
            duty_reg     <= DUTY_RST;
            first_reg    <= 1'b1;
            startup_reg  <= 1'b1;
            chg_reg      <= 1'b0;
            temp_reg     <= READING_RST;
            set_reg      <= READING_RST;
            prev_set_reg <= READING_RST;
            integ_reg    <= INTEG_RST;
            fault_reg    <= 1'b0;
            fstart_reg   <= 1'b0;
            gate_reg     <= 1'b0;
            scharge_reg  <= 1'b0;
            pcharge_reg  <= 1'b0;
        end else begin
            sync_d_reg   <= mains_sync_wake_input;
            fstate_reg   <= fstate_next;
            period_reg   <= period_next;
            duty_reg     <= duty_next;
            first_reg    <= first_next;
            startup_reg  <= startup_next;
            chg_reg      <= chg_next;
            temp_reg     <= temp_next;
            set_reg      <= set_next;
            prev_set_reg <= prev_set_next;
            integ_reg    <= integ_next;
            fault_reg    <= fault_next;
            fstart_reg   <= fstart_next;
            gate_reg     <= gate_next;
            scharge_reg  <= scharge_next;
            pcharge_reg  <= pcharge_next;
        end
    end

    // Debug serial: one 8N1 byte holding the sensor reading at each frame start.
    // A byte lasts about 1 ms, far shorter than a frame, so no queue is needed.
    mhc_tx_e     tx_state_reg, tx_state_next;
    logic [9:0]  tx_shift_reg, tx_shift_next;
    logic [3:0]  tx_bits_reg, tx_bits_next;
    logic [11:0] tx_div_reg, tx_div_next;
    logic        tx_line_reg, tx_line_next;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_shift_next = tx_shift_reg;
        tx_bits_next  = tx_bits_reg;
        tx_div_next   = tx_div_reg;
        tx_line_next  = tx_line_reg;
        case (tx_state_reg)
            MHC_TX_IDLE: begin
                tx_line_next = 1'b1;
                if (fstart_reg) begin
                    tx_state_next = MHC_TX_SHIFT;
                    tx_shift_next = {1'b1, temp_reg, 1'b0};
                    tx_bits_next  = 4'h0;
                    tx_div_next   = 12'h000;
                    tx_line_next  = 1'b0;
                end
            end
            default: begin
                if (tx_div_reg == BAUD_DIV - 12'h001) begin
                    tx_div_next = 12'h000;
                    if (tx_bits_reg == 4'h9) begin
                        tx_state_next = MHC_TX_IDLE;
                        tx_line_next  = 1'b1;
                    end else begin
                        tx_bits_next  = tx_bits_reg + 4'h1;
                        tx_shift_next = {1'b1, tx_shift_reg[9:1]};
                        tx_line_next  = tx_shift_reg[1];
                    end
                end else begin
                    tx_div_next = tx_div_reg + 12'h001;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_state_reg <= MHC_TX_IDLE;
            tx_shift_reg <= 10'h3ff;
            tx_bits_reg  <= 4'h0;
            tx_div_reg   <= 12'h000;
            tx_line_reg  <= 1'b1;
        end else begin
            tx_state_reg <= tx_state_next;
            tx_shift_reg <= tx_shift_next;
            tx_bits_reg  <= tx_bits_next;
            tx_div_reg   <= tx_div_next;
            tx_line_reg  <= tx_line_next;
        end
    end

    assign sensor_charge_output   = scharge_reg;
    assign setpoint_charge_output = pcharge_reg;
    assign gate_drive             = gate_reg;
    assign debug_serial_tx        = tx_line_reg;
    assign frame_start            = fstart_reg;
    assign change_flag            = chg_reg;
    assign reading_fault          = fault_reg;
endmodule
`default_nettype wire

// file: mhc_heater_ctrl_properties.sv
// Port-level assertion checker for the mains cycle heater controller.
`timescale 1ns/1ps
`default_nettype none
module mhc_heater_ctrl_properties (
    input wire logic mclk,                   // System clock.
    input wire logic reset,                  // Synchronous reset.
    input wire logic mains_sync_wake_input,  // Mains sync level.
    input wire logic reference_comparator,   // Comparator level.
    input wire logic sensor_charge_output,   // Sensor charge drive.
    input wire logic setpoint_charge_output, // Dial charge drive.
    input wire logic gate_drive,             // Power switch gate.
    input wire logic debug_serial_tx,        // Debug serial line.
    input wire logic frame_start             // Frame start pulse.
);
    // A full-scale charge lasts 256 ticks of 64 clocks; a few clocks of slack for the stop path.
    localparam int CHARGE_MAX = 16400;
    logic        sync_d_reg, sync_d_next;
    logic        seen_reg, seen_next;
    logic [5:0]  rise_cnt_reg, rise_cnt_next;
    logic [1:0]  frames_reg, frames_next;
    logic [14:0] chg_cnt_reg, chg_cnt_next;
    logic        charging;

    assign charging = sensor_charge_output | setpoint_charge_output;

    // Rises counted after a frame start: the rise of period k leaves k-1.
    always_comb begin
        sync_d_next   = mains_sync_wake_input;
        rise_cnt_next = frame_start ? 6'h00
                      : rise_cnt_reg + 6'(mains_sync_wake_input & ~sync_d_reg);
        seen_next     = seen_reg | frame_start;
        frames_next   = (frame_start && frames_reg != 2'h2) ? frames_reg + 2'h1 : frames_reg;
        chg_cnt_next  = charging ? chg_cnt_reg + 15'h0001 : 15'h0000;
        if (reset) begin
            sync_d_next   = 1'b0;
            rise_cnt_next = 6'h00;
            seen_next     = 1'b0;
            frames_next   = 2'h0;
            chg_cnt_next  = 15'h0000;
        end
    end

    always_ff @(posedge mclk) begin
        sync_d_reg   <= sync_d_next;
        rise_cnt_reg <= rise_cnt_next;
        seen_reg     <= seen_next;
        frames_reg   <= frames_next;
        chg_cnt_reg  <= chg_cnt_next;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence sync_rose_s;
        $past(mains_sync_wake_input) && !$past(mains_sync_wake_input, 2);
    endsequence
    sequence charge_trip_s;
        charging && reference_comparator;
    endsequence

    gate_lag_a: assert property ($rose(gate_drive) |-> sync_rose_s)
        else $error("Gate rose away from a sync rise.");
    gate_fall_a: assert property ($fell(mains_sync_wake_input) |=> !gate_drive)
        else $error("Gate still high in the negative half-wave.");
    gate_hold_a: assert property (gate_drive && mains_sync_wake_input |=> gate_drive)
        else $error("Gate pulse broken inside the positive half-wave.");
    frame_sync_a: assert property (frame_start |-> sync_rose_s)
        else $error("Frame start not tied to a sync rise.");
    frame_len_a: assert property (frame_start |-> !seen_reg || rise_cnt_reg == 6'd32)
        else $error("Frame did not last 32 periods.");
    frame_due_a: assert property (seen_reg && rise_cnt_reg == 6'd32 |-> frame_start)
        else $error("Frame start missing after 32 periods.");
    sensor_slot_a: assert property ($rose(sensor_charge_output) |->
        sync_rose_s ##0 (rise_cnt_reg == 6'd27)) else $error("Sensor timing out of its period.");
    dial_slot_a: assert property ($rose(setpoint_charge_output) |->
        sync_rose_s ##0 (rise_cnt_reg == 6'd29)) else $error("Dial timing out of its period.");
    charge_excl_a: assert property (!(sensor_charge_output && setpoint_charge_output))
        else $error("Both charge outputs driven together.");
    charge_stop_a: assert property (charge_trip_s |-> ##[1:2] !charging)
        else $error("Charge not released after comparator trip.");
    charge_sat_a: assert property (chg_cnt_reg <= CHARGE_MAX)
        else $error("Charge timing ran past saturation.");
    tx_start_a: assert property (frame_start |=> !debug_serial_tx)
        else $error("No start bit after frame start.");
    first_frame_a: assert property (gate_drive |->
        frames_reg == 2'h2 || (frames_reg == 2'h1 && frame_start))
        else $error("Gate driven in the first frame.");
endmodule

bind mhc_heater_ctrl mhc_heater_ctrl_properties u_mhc_heater_ctrl_properties (
    .mclk(mclk), .reset(reset), .mains_sync_wake_input(mains_sync_wake_input),
    .reference_comparator(reference_comparator), .sensor_charge_output(sensor_charge_output),
    .setpoint_charge_output(setpoint_charge_output), .gate_drive(gate_drive),
    .debug_serial_tx(debug_serial_tx), .frame_start(frame_start)
);
`default_nettype wire

// file: mhc_heater_ctrl_tb_top.sv
// Self-checking bench for the mains cycle heater controller.
`timescale 1ns/1ps
`default_nettype none
module mhc_heater_ctrl_tb_top;
    logic       mclk, reset, run, sync, cmp;
    logic       sens_chg, dial_chg, gate, tx, fstart, chg_flag, fault;
    logic [7:0] start_pct, sens_ticks, dial_ticks;
    int         num_errors = 0;
    int         total_checks = 0;
    int         fstart_cnt = 0;
    int         exp_tx = 0;

    mhc_heater_ctrl u_mhc_heater_ctrl (
        .mclk(mclk), .reset(reset), .mains_sync_wake_input(sync),
        .reference_comparator(cmp), .start_pct(start_pct),
        .sensor_charge_output(sens_chg), .setpoint_charge_output(dial_chg),
        .gate_drive(gate), .debug_serial_tx(tx), .frame_start(fstart),
        .change_flag(chg_flag), .reading_fault(fault)
    );

    mhc_mains_model #(.HALF(330)) u_mhc_mains_model (
        .mclk(mclk), .run(run), .sens_ticks(sens_ticks), .dial_ticks(dial_ticks),
        .sens_chg(sens_chg), .dial_chg(dial_chg), .sync(sync), .cmp(cmp)
    );

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_rise;
        while (sync !== 1'b0) begin @(posedge mclk); #1; end
        while (sync !== 1'b1) begin @(posedge mclk); #1; end
    endtask

    // Four frames take about 85000 clocks; the limit leaves a margin.
    initial begin
        repeat (95000) @(posedge mclk);
        num_errors++;
        finish_test();
    end

    always @(posedge mclk) begin
        if (fstart === 1'b1) fstart_cnt++;
    end

    // Decodes the byte sent after each frame start, sampling mid-bit.
    initial begin : serial_rx
        logic [7:0] b;
        int         i;
        forever begin
            @(posedge mclk);
            if (fstart === 1'b1) begin
                b = exp_tx[7:0];
                repeat (1041) @(posedge mclk);
                for (i = 0; i < 10; i++) begin
                    #1;
                    check(tx, (i == 0) ? 8'h00 : (i == 9) ? 8'h01 : 8'(b[i - 1]));
                    // No wait after the stop bit, so the next frame start is not missed.
                    if (i < 9) repeat (2083) @(posedge mclk);
                end
            end
        end
    end

    initial begin
        int f, p, ps, pd, cs, cd, duty;
        reset      = 1'b1;
        run        = 1'b0;
        sens_ticks = 8'h05;
        dial_ticks = 8'h10;
        void'($urandom(32'h2165165d));
        start_pct  = 8'(50 + $urandom % 50);
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        run   <= 1'b1;
        ps = 0;
        pd = 0;
        for (f = 1; f <= 4; f++) begin
            // Duty comes from the readings of the frame before.
            duty = (f == 1 || pd <= 8) ? 0 : (ps * 100 < pd * start_pct) ? 32 : 0;
            exp_tx = ps;
            cs = (f <= 2) ? 3 + $urandom % 4 : 7 + $urandom % 3;
            cd = (f <= 2) ? 16 : 4;
            for (p = 1; p <= 32; p++) begin
                wait_rise();
                if (p == 1) begin
                    sens_ticks <= 8'(cs);
                    dial_ticks <= 8'(cd);
                end
                repeat (10) @(posedge mclk);
                #1;
                if (p == 1) check(8'(fstart_cnt), 8'(f));
                if (f == 1 && p == 1) check(chg_flag, 8'h00);
                if (p <= 30) check(sens_chg, 8'(p == 28));
                if (p <= 30) check(dial_chg, 8'(p == 30));
                if (f == 1 && p == 32) check(chg_flag, 8'h01);
                if (p == 32) check(fault, 8'h00);
                repeat (140) @(posedge mclk);
                #1;
                check(gate, 8'(p <= duty));
                repeat (330) @(posedge mclk);
                #1;
                check(gate, 8'h00);
            end
            ps = cs;
            pd = cd;
        end
        finish_test();
    end
endmodule
`default_nettype wire

// file: mhc_mains_model.sv
// Behavioural mains sync source and RC charge network facing the heater controller.
`timescale 1ns/1ps
`default_nettype none
module mhc_mains_model #(
    parameter int HALF = 330  // Clocks per half-wave.
) (
    input  wire logic       mclk,       // System clock.
    input  wire logic       run,        // Mains present.
    input  wire logic [7:0] sens_ticks, // Sensor charge time in ticks.
    input  wire logic [7:0] dial_ticks, // Dial charge time in ticks.
    input  wire logic       sens_chg,   // Sensor charge drive.
    input  wire logic       dial_chg,   // Dial charge drive.
    output logic            sync,       // High in the positive half-wave.
    output logic            cmp         // High once the capacitor passes the reference.
);
    int phase = 0;
    int chg   = 0;

    initial begin
        sync = 1'b0;
        cmp  = 1'b0;
    end

    // Trip lands mid-tick so the expected count does not hinge on the tick phase.
    always @(posedge mclk) begin
        phase <= (!run || phase == 2 * HALF - 1) ? 0 : phase + 1;
        sync  <= run && phase < HALF;
        chg   <= (sens_chg || dial_chg) ? chg + 1 : 0;
        cmp   <= (sens_chg && chg >= 64 * sens_ticks + 32)
              || (dial_chg && chg >= 64 * dial_ticks + 32);
    end
endmodule
`default_nettype wire

// file: mhc_pkg.sv
// Shared constants and carrier types for the mains cycle heater controller.
package mhc_pkg;

    // System clock and derived serial timing.
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned BAUD_RATE     = 9600;
    localparam logic [11:0] BAUD_DIV      = 12'(CLK_HZ / BAUD_RATE);

    // Frame structure, counted in mains periods (one period starts at a sync rising edge).
    localparam logic [5:0]  FRAME_PERIODS     = 6'h20;
    localparam int unsigned FRAME_TIME_MS     = 640;
    localparam logic [5:0]  MEAS_SENSOR_PER   = 6'h1c;
    localparam logic [5:0]  MEAS_SETPOINT_PER = 6'h1e;

    // Charge-time counter: one count per TICK_DIV system clocks.
    localparam logic [7:0]  TICK_DIV      = 8'h40;

    // Override thresholds in percent.
    localparam logic [7:0]  START_PCT     = 8'h59;
    localparam logic [7:0]  RISE_PCT      = 8'h6f;
    localparam logic [7:0]  FALL_PCT      = 8'h59;

    // Setpoint readings at or below this count mean the dial is in its off position.
    localparam logic [7:0]  SETPOINT_OFF  = 8'h08;

    // Reset values.
    localparam logic [5:0]  DUTY_RST      = 6'h00;
    localparam logic [7:0]  READING_RST   = 8'h00;
    localparam logic [15:0] INTEG_RST     = 16'h0000;

    typedef struct packed {
        logic [7:0] count;   // Charge time in ticks.
        logic       over;    // Comparator never tripped; reading out of range.
    } mhc_meas_s;

    typedef enum logic {MHC_WAIT, MHC_RUN} mhc_frame_e;
    typedef enum logic {MHC_TX_IDLE, MHC_TX_SHIFT} mhc_tx_e;
    typedef enum logic {MHC_MEAS_IDLE, MHC_MEAS_BUSY} mhc_meas_e;

endpackage
